// >>> fsw_pkg.sv
// Summary of operation
// RL1 - Write-disable command clears the write latch
// RL2 - Latch cleared at power-up and write completions
// RL3 - Opcode 05h low byte, 35h high byte
// RL4 - Status readable anytime, repeats while clocked
// RL5 - Host polls busy before new commands
// RL6 - Busy bit0 set during cycles, cleared after
// RL7 - While busy, only status/suspend/resume accepted
// RL8 - Latch bit1 set by enable, cleared by suspend
// RL9 - Protect level bits at 4..2, non-volatile
// RL10 - Bottom bit chooses protection origin, default 0
// RL11 - Bit6 selects sector or block granularity
// RL12 - Bit9 quad enable turns pins into data
// RL13 - Bit10 locks whole array after power-on
// RL14 - Power-on forces levels per lock and invert
// RL15 - Bit14 inverts the protected region
// RL16 - Bit15 suspended flag, set/clear by suspend/resume
// RL17 - Status write needs the latch already set
// RL18 - Only writable bits change, others read 0
// RL19 - Status write must end at 8 or 16
// RL20 - Eight-bit write clears invert, quad, lock hi
// RL21 - Valid write starts timed busy cycle
// RL22 - Lock bits and protect pin gate writes
package fsw_pkg;
    localparam logic [7:0] OP_WR_ON_C  = 8'h06;
    localparam logic [7:0] OP_WR_OFF_C = 8'h04;
    localparam logic [7:0] OP_RD_LO_C  = 8'h05;
    localparam logic [7:0] OP_RD_HI_C  = 8'h35;
    localparam logic [7:0] OP_ST_WR_C  = 8'h01;
    localparam logic [7:0] OP_PAGE_C   = 8'h02;
    localparam logic [7:0] OP_DUAL_C   = 8'ha2;
    localparam logic [7:0] OP_QUAD_C   = 8'h32;
    localparam logic [7:0] OP_OTP_C    = 8'h42;
    localparam logic [7:0] OP_SECT_C   = 8'h20;
    localparam logic [7:0] OP_BLK_C    = 8'hd8;
    localparam logic [7:0] OP_BLK2_C   = 8'h52;
    localparam logic [7:0] OP_CHIP_C   = 8'hc7;
    localparam logic [7:0] OP_CHIP2_C  = 8'h60;
    localparam logic [7:0] OP_SUSP_C   = 8'hb0;
    localparam logic [7:0] OP_RESM_C   = 8'h7a;
    localparam logic [7:0] OP_RESM2_C  = 8'h30;
    localparam int BUSY_BIT_C   = 0;
    localparam int LATCH_BIT_C   = 1;
    localparam int BP_LSB_C      = 2;
    localparam int BOTTOM_BIT_C  = 5;
    localparam int GRAN_BIT_C    = 6;
    localparam int LOCKLO_BIT_C  = 7;
    localparam int LOCKHI_BIT_C  = 8;
    localparam int QUAD_BIT_C    = 9;
    localparam int PONLOCK_BIT_C = 10;
    localparam int INVERT_BIT_C  = 14;
    localparam int SUSP_BIT_C    = 15;
    localparam logic [15:0] WR_MASK_C  = 16'h47fc;
    localparam logic [15:0] NV_RESET_C = 16'h0000;
    localparam int CLK_HZ_C        = 10_000_000;
    localparam int T_STWR_US_C     = 100;
    localparam int T_PROG_US_C     = 1500;
    localparam int STWR_CYC_C = T_STWR_US_C * (CLK_HZ_C / 1_000_000);
    localparam int PROG_CYC_C = T_PROG_US_C * (CLK_HZ_C / 1_000_000);
    typedef struct packed {
        logic sck;
        logic cs_n;
        logic mosi;
    } fsw_spi_s;
    typedef enum logic [1:0] {
        ST_IDLE = 2'b00,
        ST_CMD  = 2'b01,
        ST_DATA = 2'b10,
        ST_SKIP = 2'b11
    } fsw_state_e;
endpackage : fsw_pkg

// >>> fsw_sync.sv
`timescale 1ns/1ps
module fsw_sync #(
    parameter int W = 4
) (
    input  wire logic         clk_in,
    input  wire logic         rst_in,
    input  wire logic [W-1:0] d_in,
    output logic      [W-1:0] q_out
);
    logic [W-1:0] meta;
    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            meta  <= '1;
            q_out <= '1;
        end else begin
            meta  <= d_in;
            q_out <= meta;
        end
    end
endmodule : fsw_sync

// >>> fsw_top.sv
`timescale 1ns/1ps
module fsw_top
    import fsw_pkg::*;
#(
    parameter int STWR_CYCLES = STWR_CYC_C,
    parameter int PROG_CYCLES = PROG_CYC_C
) (
    input  wire logic             clk_in,
    input  wire logic             rst_in,
    input  wire fsw_pkg::fsw_spi_s spi_in,
    input  wire logic             wp_n_in,
    output logic                  miso_out,
    output logic                  quad_mode_out,
    output logic                  busy_out
);
    import fsw_pkg::*;
    // ==========================================================
    // Pin synchronisers
    // ==========================================================
    logic [3:0] sync_q;
    fsw_sync #(.W(4)) u_sync (
        .clk_in (clk_in),
        .rst_in (rst_in),
        .d_in   ({spi_in.sck, spi_in.cs_n, spi_in.mosi, wp_n_in}),
        .q_out  (sync_q)
    );
    logic sck_d;
    wire  sck_s  = sync_q[3];
    wire  cs_s   = sync_q[2];
    wire  mosi_s = sync_q[1];
    wire  wp_s   = sync_q[0];
    logic cs_d;
    wire  sck_rise = sck_s & ~sck_d;
    wire  sck_fall = ~sck_s & sck_d;
    wire  cs_rise  = cs_s & ~cs_d;
    wire  cs_fall  = ~cs_s & cs_d;

    // ==========================================================
    // Status state
    // ==========================================================
    logic [15:0] nv = NV_RESET_C;
    logic        wr_latch;
    logic        susp;
    logic        busy;
    logic [31:0] busy_cnt;
    logic        init_done;
    fsw_state_e  state;
    logic [7:0]  opcode;
    logic [4:0]  bitcnt;
    logic [15:0] shreg;
    logic [7:0]  txreg;
    logic [2:0]  txcnt;
    logic        rd_hi;
    logic        reading;

    wire [15:0] status = {susp, nv[14:8], nv[7:2], wr_latch, busy}
                         & (WR_MASK_C | 16'h8003); // RL18
    // Pin in protection code 01 only blocks while low
    wire lock_ok = (~nv[LOCKHI_BIT_C] & ~nv[LOCKLO_BIT_C])
                 | (~nv[LOCKHI_BIT_C] & nv[LOCKLO_BIT_C] & wp_s); // RL22

    // Completed opcode seen at chip-select rise
    wire [7:0] op_done = opcode;
    wire is_prog = (op_done == OP_PAGE_C) || (op_done == OP_DUAL_C)
                || (op_done == OP_QUAD_C) || (op_done == OP_OTP_C)
                || (op_done == OP_SECT_C) || (op_done == OP_BLK_C)
                || (op_done == OP_BLK2_C) || (op_done == OP_CHIP_C)
                || (op_done == OP_CHIP2_C);
    wire is_resume = (op_done == OP_RESM_C) || (op_done == OP_RESM2_C);
    wire full_byte = (bitcnt == 5'd8);
    wire frame_end = cs_rise && (state != ST_IDLE);
    wire cmd_ok    = frame_end && full_byte && state == ST_CMD;
    // Busy blocks all but status, suspend and resume
    wire allowed   = ~busy || op_done == OP_SUSP_C || is_resume; // RL7
    wire do_wr_on  = cmd_ok && op_done == OP_WR_ON_C && allowed;
    wire do_wr_off = cmd_ok && op_done == OP_WR_OFF_C && allowed; // RL1
    wire do_prog   = cmd_ok && is_prog && ~busy && wr_latch;
    wire do_susp   = cmd_ok && op_done == OP_SUSP_C && busy;
    wire do_resm   = cmd_ok && is_resume && susp;
    wire stwr_len8  = state == ST_DATA && bitcnt == 5'd8;
    wire stwr_len16 = state == ST_DATA && bitcnt == 5'd16;
    wire do_stwr = frame_end && opcode == OP_ST_WR_C && ~busy && wr_latch
                 && lock_ok && (stwr_len8 || stwr_len16); // RL17 RL19
    wire [15:0] wr_val = stwr_len16 ? {shreg[7:0], shreg[15:8]}
                                    : {8'h00, shreg[7:0]};
    // Short write keeps the power-on lock bit
    wire [15:0] wr_mask = stwr_len16 ? WR_MASK_C
                        : (WR_MASK_C & ~(16'h0001 << PONLOCK_BIT_C)); // RL20
    wire [15:0] next_nv = (nv & ~wr_mask) | (wr_val & wr_mask);
    wire busy_done = busy && busy_cnt == 32'd1;
    wire [7:0] tx_byte = rd_hi ? status[15:8] : status[7:0];

    // ==========================================================
    // Serial framing
    // ==========================================================
    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            sck_d   <= 1'b1;
            cs_d    <= 1'b1;
            state   <= ST_IDLE;
            opcode  <= 8'h00;
            bitcnt  <= 5'd0;
            shreg   <= 16'h0000;
        end else begin
            sck_d <= sck_s;
            cs_d  <= cs_s;
            if (cs_s) begin
                state <= ST_IDLE;
            end else if (cs_fall) begin
                state  <= ST_CMD;
                bitcnt <= 5'd0;
                opcode <= 8'h00;
            end else if (sck_rise) begin
                case (state)
                    ST_CMD: begin
                        if (bitcnt == 5'd8) begin
                            state  <= (opcode == OP_ST_WR_C) ? ST_DATA
                                                            : ST_SKIP;
                            bitcnt <= 5'd1;
                            shreg  <= {15'h0000, mosi_s};
                        end else begin
                            opcode <= {opcode[6:0], mosi_s};
                            bitcnt <= bitcnt + 5'd1;
                        end
                    end
                    ST_DATA: begin
                        shreg  <= {shreg[14:0], mosi_s};
                        if (bitcnt != 5'd31) begin
                            bitcnt <= bitcnt + 5'd1;
                        end
                    end
                    ST_SKIP: begin
                        bitcnt <= 5'd31;
                    end
                    default: begin
                        state <= ST_IDLE;
                    end
                endcase
            end
        end
    end

    // ==========================================================
    // Status shift-out
    // ==========================================================
    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            reading  <= 1'b0;
            rd_hi    <= 1'b0;
            txreg    <= 8'h00;
            txcnt    <= 3'd0;
            miso_out <= 1'b0;
        end else if (cs_s) begin
            reading <= 1'b0;
        end else if (state == ST_CMD && bitcnt == 5'd8 && ~reading
                     && (opcode == OP_RD_LO_C
                         || opcode == OP_RD_HI_C)) begin
            reading <= 1'b1;                                   // RL3
            rd_hi   <= (opcode == OP_RD_HI_C);
            txcnt   <= 3'd0;
        end else if (reading && sck_fall) begin
            // Reload each byte so a long read tracks live status
            if (txcnt == 3'd0) begin
                miso_out <= tx_byte[7];                        // RL4
                txreg    <= {tx_byte[6:0], 1'b0};
            end else begin
                miso_out <= txreg[7];
                txreg    <= {txreg[6:0], 1'b0};
            end
            txcnt <= txcnt + 3'd1;
        end
    end

    // ==========================================================
    // Status bits and timed cycle
    // ==========================================================
    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            wr_latch  <= 1'b0;                                 // RL2
            susp      <= 1'b0;
            busy      <= 1'b0;
            busy_cnt  <= 32'd0;
            init_done <= 1'b0;
        end else begin
            init_done <= 1'b1;
            if (do_wr_on) begin
                wr_latch <= 1'b1;
            end
            if (do_wr_off || do_susp || busy_done) begin
                wr_latch <= 1'b0;                              // RL8 RL2
            end
            if (do_stwr) begin
                busy     <= 1'b1;                              // RL21
                busy_cnt <= 32'(STWR_CYCLES);
            end else if (do_prog) begin
                busy     <= 1'b1;
                busy_cnt <= 32'(PROG_CYCLES);
            end else if (do_susp) begin
                busy <= 1'b0;                                  // RL6
                susp <= 1'b1;                                  // RL16
            end else if (do_resm) begin
                busy <= 1'b1;
                susp <= 1'b0;
            end else if (busy_done) begin
                busy     <= 1'b0;
                busy_cnt <= 32'd0;
            end else if (busy) begin
                busy_cnt <= busy_cnt - 32'd1;
            end
        end
    end

    // Non-volatile bits keep their value over reset, except the protect levels, which the power-on lock bit forces after it
    always_ff @(posedge clk_in) begin
        if (~rst_in && ~init_done && nv[PONLOCK_BIT_C]) begin
            nv[BP_LSB_C +: 3] <= nv[INVERT_BIT_C] ? 3'b000 : 3'b111; // RL14
        end else if (~rst_in && do_stwr) begin
            nv <= next_nv;          // RL9 RL10 RL11 RL12 RL13 RL15 RL20
        end
    end

    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            quad_mode_out <= 1'b0;
            busy_out      <= 1'b0;
        end else begin
            quad_mode_out <= nv[QUAD_BIT_C];                   // RL12
            busy_out      <= busy;
        end
    end

    // ==========================================================
    // Checks
    // ==========================================================
    a_stwr_sets_busy: assert property (@(posedge clk_in) // RL21
        disable iff (rst_in) do_stwr |=> busy)
        else $error("busy not set after status write");
    a_off_clears_latch: assert property (@(posedge clk_in) // RL1
        disable iff (rst_in) do_wr_off |=> ~wr_latch)
        else $error("latch not cleared by disable");
    a_stwr_needs_latch: assert property (@(posedge clk_in) // RL17
        disable iff (rst_in) do_stwr |-> wr_latch)
        else $error("status write without latch");
    a_lock_blocks_write: assert property (@(posedge clk_in) // RL22
        disable iff (rst_in)
        (nv[LOCKHI_BIT_C] && nv[LOCKLO_BIT_C]) |-> ~do_stwr)
        else $error("locked status written");
    a_busy_ignores: assert property (@(posedge clk_in) // RL7
        disable iff (rst_in) busy |-> ~do_wr_on && ~do_prog)
        else $error("command accepted while busy");
    a_susp_clears: assert property (@(posedge clk_in) // RL6
        disable iff (rst_in) do_susp |=> ~busy && ~wr_latch && susp)
        else $error("suspend did not clear busy");
    a_len8_clears: assert property (@(posedge clk_in) // RL20
        disable iff (rst_in) (do_stwr && stwr_len8) |=>
        ~nv[INVERT_BIT_C] && ~nv[QUAD_BIT_C] && ~nv[LOCKHI_BIT_C]
        && nv[PONLOCK_BIT_C] == $past(nv[PONLOCK_BIT_C]))
        else $error("short write kept high bits");
    a_reserved_zero: assert property (@(posedge clk_in) // RL18
        disable iff (rst_in) status[13:11] == 3'b000)
        else $error("reserved status bits nonzero");
endmodule : fsw_top

// >>> fsw_host.sv
`timescale 1ns/1ps
// ==========================================
// Host side: mode 0 controller, clock idles low
module fsw_host
    import fsw_pkg::*;
(
    input  wire logic     clk_in,
    input  wire logic     miso_in,
    output fsw_pkg::fsw_spi_s spi_out
);
    initial spi_out = '{sck: 1'b0, cs_n: 1'b1, mosi: 1'b0};
    task automatic half();
        repeat (4) @(negedge clk_in);
    endtask : half
    // Sample late in the high phase: the answer trails the fall
    task automatic frame(input logic [31:0] bits, input int n,
                         output logic [15:0] rd);
        rd = 16'h0000;
        spi_out.cs_n = 1'b0;
        half();
        for (int i = 0; i < n; i++) begin
            spi_out.mosi = bits[31-i];
            half();
            spi_out.sck = 1'b1;
            half();
            rd = {rd[14:0], miso_in};
            spi_out.sck = 1'b0;
        end
        half();
        spi_out.cs_n = 1'b1;
        spi_out.mosi = ~spi_out.mosi;
        half();
        half();
    endtask : frame
endmodule : fsw_host

// >>> testbench.sv
`timescale 1ns/1ps
// ==========================================
// Self-checking bench
module testbench;
    import fsw_pkg::*;
    logic        clk_in;
    logic        rst_in;
    logic        wp_n_in;
    fsw_spi_s    spi;
    logic        miso;
    logic        quad;
    logic        busy;
    logic [15:0] rd;
    int          err_count;
    int          n_tests;
    fsw_top #(.STWR_CYCLES(400), .PROG_CYCLES(800)) i_fsw_top (
        .clk_in(clk_in), .rst_in(rst_in), .spi_in(spi), .wp_n_in(wp_n_in),
        .miso_out(miso), .quad_mode_out(quad), .busy_out(busy));
    fsw_host i_fsw_host (.clk_in(clk_in), .miso_in(miso), .spi_out(spi));
    initial begin
        clk_in = 1'b0;
        forever #50 clk_in = ~clk_in;
    end
    task automatic conclude();
        $display("Checks %0d mismatches %0d", n_tests, err_count);
        if (err_count == 0 && n_tests > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask : conclude
    task automatic chk(string nm, logic [15:0] e, logic [15:0] g);
        n_tests++;
        if (g !== e) begin
            $display("Error %s expected %h seen %h", nm, e, g);
            err_count++;
        end
    endtask : chk
    task automatic cmd(logic [7:0] op);
        i_fsw_host.frame({op, 24'h0}, 8, rd);
    endtask : cmd
    // Low byte goes first; an 8-bit write carries only d[15:8]
    task automatic wr(int n, logic [15:0] d);
        i_fsw_host.frame({OP_ST_WR_C, d, 8'h00}, 8 + n, rd);
    endtask : wr
    task automatic rs(logic [7:0] op, logic [7:0] e);
        i_fsw_host.frame({op, 24'h0}, 16, rd);
        chk("status", {8'h00, e}, {8'h00, rd[7:0]});
    endtask : rs
    // Polls busy the way a careful host would, with a bound
    task automatic idle();
        int i;
        for (i = 0; i < 2000 && busy !== 1'b0; i++) @(negedge clk_in);
        if (i == 2000) begin
            $display("Error busy expected 0 seen %b", busy);
            err_count++;
            conclude();
        end
    endtask : idle
    task automatic t_reset();
        rs(OP_RD_LO_C, 8'h00);
        rs(OP_RD_HI_C, 8'h00);
        $display("reset values done");
    endtask : t_reset
    task automatic t_latch();
        cmd(OP_WR_ON_C);
        rs(OP_RD_LO_C, 8'h02);
        cmd(OP_WR_OFF_C);
        rs(OP_RD_LO_C, 8'h00);
        wr(8, 16'hff00);
        chk("busy", 16'h0, {15'h0, busy});
        rs(OP_RD_LO_C, 8'h00);
        $display("latch done");
    endtask : t_latch
    task automatic t_write16();
        cmd(OP_WR_ON_C);
        wr(16, 16'h7fc6);
        chk("busy", 16'h1, {15'h0, busy});
        i_fsw_host.frame({OP_RD_LO_C, 24'h0}, 16, rd);
        chk("busy bit", 16'h1, {15'h0, rd[0]});
        idle();
        i_fsw_host.frame({OP_RD_LO_C, 24'h0}, 24, rd);
        chk("repeat", 16'h7c7c, rd);
        rs(OP_RD_LO_C, 8'h7c);
        rs(OP_RD_HI_C, 8'h46);
        chk("quad", 16'h1, {15'h0, quad});
        $display("write 16 done");
    endtask : t_write16
    task automatic t_write8();
        cmd(OP_WR_ON_C);
        wr(8, 16'h0000);
        idle();
        rs(OP_RD_HI_C, 8'h04);
        chk("quad", 16'h0, {15'h0, quad});
        rs(OP_RD_LO_C, 8'h00);
        cmd(OP_WR_ON_C);
        wr(12, 16'hfff0);
        chk("busy", 16'h0, {15'h0, busy});
        rs(OP_RD_LO_C, 8'h02);
        cmd(OP_WR_OFF_C);
        $display("write 8 and bad length done");
    endtask : t_write8
    task automatic t_suspend();
        cmd(OP_WR_ON_C);
        cmd(OP_PAGE_C);
        wr(16, 16'h1c00);
        cmd(OP_SUSP_C);
        chk("busy", 16'h0, {15'h0, busy});
        rs(OP_RD_HI_C, 8'h84);
        rs(OP_RD_LO_C, 8'h00);
        cmd(OP_RESM_C);
        rs(OP_RD_HI_C, 8'h04);
        idle();
        rs(OP_RD_LO_C, 8'h00);
        $display("suspend done");
    endtask : t_suspend
    task automatic t_lock();
        cmd(OP_WR_ON_C);
        wr(8, 16'h8000);
        idle();
        wp_n_in = 1'b0;
        cmd(OP_WR_ON_C);
        wr(8, 16'h0000);
        idle();
        cmd(OP_WR_OFF_C);
        rs(OP_RD_LO_C, 8'h80);
        wp_n_in = 1'b1;
        cmd(OP_WR_ON_C);
        wr(8, 16'h0000);
        idle();
        rs(OP_RD_LO_C, 8'h00);
        rst_in = 1'b1;
        repeat (8) @(negedge clk_in);
        rst_in = 1'b0;
        repeat (4) @(negedge clk_in);
        rs(OP_RD_LO_C, 8'h1c);
        $display("lock and power-on done");
    endtask : t_lock
    initial begin
        rst_in = 1'b1;
        wp_n_in = 1'b1;
        err_count = 0;
        n_tests = 0;
        repeat (8) @(negedge clk_in);
        rst_in = 1'b0;
        repeat (4) @(negedge clk_in);
        t_reset();
        t_latch();
        t_write16();
        t_write8();
        t_suspend();
        t_lock();
        conclude();
    end
endmodule : testbench
